// [pkg/ppa_defines.svh]
`ifndef PPA_DEFINES_SVH
`define PPA_DEFINES_SVH

// Byte offsets of the software registers
`define PPA_OFS_ADDR 8'h00
`define PPA_OFS_PADEN 8'h04
`define PPA_OFS_MODE 8'h08
`define PPA_OFS_STAT 8'h0c

// Word indices, byte offset divided by four
`define PPA_IDX_ADDR 2'h0
`define PPA_IDX_PADEN 2'h1
`define PPA_IDX_MODE 2'h2
`define PPA_IDX_STAT 2'h3

// Lowest address bit above the register window
`define PPA_WIN_TOP 4

// Reset values
`define PPA_RST_ADDR 16'h0000
`define PPA_RST_PADEN 16'h0000
`define PPA_RST_MODE 16'h0000

// Field positions in the address and chip-select register
`define PPA_CS2_BIT 15
`define PPA_CS1_BIT 14

// Field positions in the pad mode register
`define PPA_MODE_CS_BIT 0
`define PPA_MODE_ALS_BIT 1

// AXI response codes
`define PPA_RESP_OKAY 2'h0
`define PPA_RESP_SLVERR 2'h2

`endif

// [pkg/ppa_pkg.sv]
package ppa_pkg;

  // Pad bundle: driven level and output enable per pad
  typedef struct packed {
    logic [15:0] oe;
    logic [15:0] dat;
  } ppa_pad_t;

  // Write channel progress
  typedef enum logic {
    PPA_W_IDLE = 1'b0,
    PPA_W_RESP = 1'b1
  } ppa_wrState_t;

  // Read channel progress
  typedef enum logic {
    PPA_R_IDLE = 1'b0,
    PPA_R_DATA = 1'b1
  } ppa_rdState_t;

endpackage

// [src/ppa_reg16.sv]
`timescale 1ns/100ps
`default_nettype none
module ppa_reg16 #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write side
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic [1:0] wrStrb,
  // Stored value
  output logic [15:0] q
);

  // Each byte lane updates only when its strobe is set
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else if (wrEn) begin
      if (wrStrb[0]) begin
        q[7:0] <= wrData[7:0];
      end
      if (wrStrb[1]) begin
        q[15:8] <= wrData[15:8];
      end
    end
  end

endmodule // ppa_reg16
`default_nettype wire

// [src/ppa_pad_mux.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
module ppa_pad_mux #(
  parameter bit CS_ACTIVE_HIGH = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register contents
  input wire logic [15:0] addrReg,
  input wire logic [15:0] padEn,
  input wire logic csPadMode,
  input wire logic strobePadMode,
  // Port I/O fallback and latch strobes
  input wire ppa_pkg::ppa_pad_t portIo,
  input wire logic latchHigh,
  input wire logic latchLow,
  // Registered pad and chip-select outputs
  output ppa_pkg::ppa_pad_t pads,
  output logic csTwo,
  output logic csOne
);
  import ppa_pkg::*;

  // Function value that each pad would carry when enabled
  logic [15:0] funcVal;
  // Next pad state
  ppa_pad_t padNxt;
  // Chip-select pin levels for the current register bits
  logic [1:0] csLvl;

  // Chip-select bit to pin level
  function automatic logic [1:0] csLevel(input logic [1:0] bits);
    return CS_ACTIVE_HIGH ? bits : ~bits;
  endfunction

  // Pick address or the special function for each pad
  always_comb begin
    funcVal = addrReg;
    if (csPadMode) begin
      funcVal[15:14] = csLevel(addrReg[15:14]);
    end
    if (strobePadMode) begin
      funcVal[1:0] = {latchHigh, latchLow};
    end
  end

  // Enabled pads take the function, others stay port I/O
  always_comb begin
    padNxt = portIo;
    for (int i = 14; i < 16; i++) begin
      if (padEn[i]) begin
        padNxt.dat[i] = funcVal[i];
        padNxt.oe[i] = 1'b1;
      end
    end
    for (int i = 2; i < 14; i++) begin
      if (padEn[i]) begin
        padNxt.dat[i] = funcVal[i];
        padNxt.oe[i] = 1'b1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (padEn[i]) begin
        padNxt.dat[i] = funcVal[i];
        padNxt.oe[i] = 1'b1;
      end
    end
  end

  // Pads are registered so the pins never see decode glitches
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pads <= '0;
    end else begin
      pads <= padNxt;
    end
  end

  // Levels taken through a net, since a function result cannot be indexed
  assign csLvl = csLevel(addrReg[`PPA_CS2_BIT -: 2]);

  // Chip selects follow their register bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // Inactive level is the inverse of the active one
      csTwo <= ~CS_ACTIVE_HIGH;
      csOne <= ~CS_ACTIVE_HIGH;
    end else begin
      csTwo <= csLvl[1];
      csOne <= csLvl[0];
    end
  end

endmodule // ppa_pad_mux
`default_nettype wire

// [src/ppa_port_top.sv]
// Overview of operation
// - Second chip select follows address register top bit
// - First chip select follows address register bit 14
// - Low fourteen bits form the destination address
// - Pad enables 15:14 give address or chip selects
// - Pad enables 13:2 give address lines
// - Pad enables 1:0 give address or latch strobes
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
module ppa_port_top #(
  parameter int ADDR_W = 8,
  parameter bit CS_ACTIVE_HIGH = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port I/O values used while a pad is not enabled
  input wire ppa_pkg::ppa_pad_t portIo,
  // Address-latch strobes from the strobe sequencer
  input wire logic latchHighStrobeIn,
  input wire logic latchLowStrobeIn,
  // Pads and chip selects
  output ppa_pkg::ppa_pad_t portAddressPads,
  output logic chipSelectTwoOut,
  output logic chipSelectOneOut
);
  import ppa_pkg::*;

  // Write channel registers
  logic awReady_r; // Address slot free
  logic wReady_r; // Data slot free
  logic awHeld_r; // Address captured, waiting for data
  logic wHeld_r; // Data captured, waiting for address
  logic [ADDR_W-1:0] awAddr_r; // Captured write address
  logic [31:0] wData_r; // Captured write data
  logic [3:0] wStrb_r; // Captured byte strobes
  logic bValid_r; // Response pending
  logic [1:0] bResp_r; // Response code
  ppa_wrState_t wState_r; // Write progress

  // Read channel registers
  logic arReady_r; // Read address slot free
  logic rValid_r; // Read data pending
  logic [31:0] rData_r; // Read data
  logic [1:0] rResp_r; // Read response code
  ppa_rdState_t rState_r; // Read progress

  // Register contents
  logic [15:0] portAddrReg; // Address and chip-select register
  logic [15:0] padEnReg; // Pad enable register
  logic [15:0] modeReg; // Pad mode register, two bits used

  // Pad state seen by the status register, and the chip-select outputs
  ppa_pad_t padState;
  logic csTwo;
  logic csOne;

  // Write decode
  logic doWrite; // Both halves of a write are here
  logic wrMapped; // Write address hits a register
  logic [1:0] wrIdx; // Word index of the write
  logic wrAddrEn; // Strobe for the address register
  logic wrPadEnEn; // Strobe for the pad enable register
  logic wrModeEn; // Strobe for the mode register

  // Read decode
  logic [31:0] rdWord; // Word at the read address

  // True when the address falls inside the register window
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:`PPA_WIN_TOP] == '0;
  endfunction

  // Word index inside the register window
  function automatic logic [1:0] wordIdx(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction

  // The write is carried out once address and data are both held
  assign doWrite = (wState_r == PPA_W_IDLE) && awHeld_r && wHeld_r;
  assign wrMapped = isMapped(awAddr_r);
  assign wrIdx = wordIdx(awAddr_r);

  // One strobe per writable register; status is read only
  assign wrAddrEn = doWrite && wrMapped && (wrIdx == `PPA_IDX_ADDR);
  assign wrPadEnEn = doWrite && wrMapped && (wrIdx == `PPA_IDX_PADEN);
  assign wrModeEn = doWrite && wrMapped && (wrIdx == `PPA_IDX_MODE);

  // Address slot: open only while idle and empty
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awReady_r <= 1'b0;
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && awReady_r) begin
      // Take the address and close the slot
      awReady_r <= 1'b0;
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      // Consumed; slot reopens after the response
      awHeld_r <= 1'b0;
    end else if (wState_r == PPA_W_IDLE && !awHeld_r) begin
      awReady_r <= 1'b1;
    end
  end

  // Data slot: same scheme, independent of the address slot
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wReady_r <= 1'b0;
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (s_axi_wvalid && wReady_r) begin
      // Take the data and close the slot
      wReady_r <= 1'b0;
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end else if (wState_r == PPA_W_IDLE && !wHeld_r) begin
      wReady_r <= 1'b1;
    end
  end

  // Write response: one per write, unmapped words answer an error
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wState_r <= PPA_W_IDLE;
      bValid_r <= 1'b0;
      bResp_r <= `PPA_RESP_OKAY;
    end else begin
      unique case (wState_r)
        PPA_W_IDLE: begin
          if (doWrite) begin
            // Writes to the status word are ignored but accepted
            wState_r <= PPA_W_RESP;
            bValid_r <= 1'b1;
            bResp_r <= wrMapped ? `PPA_RESP_OKAY : `PPA_RESP_SLVERR;
          end
        end
        PPA_W_RESP: begin
          if (s_axi_bready) begin
            wState_r <= PPA_W_IDLE;
            bValid_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Address and chip-select register, cleared at reset
  ppa_reg16 #(
    .RESET_VAL(`PPA_RST_ADDR)
  ) u_addrReg (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrAddrEn),
    .wrData(wData_r[15:0]),
    .wrStrb(wStrb_r[1:0]),
    .q(portAddrReg)
  );

  // Pad enable register, cleared at reset so all pads are port I/O
  ppa_reg16 #(
    .RESET_VAL(`PPA_RST_PADEN)
  ) u_padEnReg (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrPadEnEn),
    .wrData(wData_r[15:0]),
    .wrStrb(wStrb_r[1:0]),
    .q(padEnReg)
  );

  // Pad mode register: chip-select and latch-strobe function choice
  ppa_reg16 #(
    .RESET_VAL(`PPA_RST_MODE)
  ) u_modeReg (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrModeEn),
    .wrData(wData_r[15:0]),
    .wrStrb(wStrb_r[1:0]),
    .q(modeReg)
  );

  // Pad function selection and registered pin drive
  ppa_pad_mux #(
    .CS_ACTIVE_HIGH(CS_ACTIVE_HIGH)
  ) u_padMux (
    .clk(clk),
    .rst_b(rst_b),
    .addrReg(portAddrReg),
    .padEn(padEnReg),
    .csPadMode(modeReg[`PPA_MODE_CS_BIT]),
    .strobePadMode(modeReg[`PPA_MODE_ALS_BIT]),
    .portIo(portIo),
    .latchHigh(latchHighStrobeIn),
    .latchLow(latchLowStrobeIn),
    .pads(padState),
    .csTwo(csTwo),
    .csOne(csOne)
  );

  // Read word selection; reserved bits read as zero
  always_comb begin
    rdWord = '0;
    unique case (wordIdx(s_axi_araddr))
      `PPA_IDX_ADDR: rdWord = {16'h0000, portAddrReg};
      `PPA_IDX_PADEN: rdWord = {16'h0000, padEnReg};
      `PPA_IDX_MODE: rdWord = {30'h00000000, modeReg[1:0]};
      `PPA_IDX_STAT: rdWord = {padState.oe, padState.dat};
    endcase
    if (!isMapped(s_axi_araddr)) begin
      // Outside the window: zero data, error response
      rdWord = '0;
    end
  end

  // Read channel: one read in flight, data held until taken
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rState_r <= PPA_R_IDLE;
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= `PPA_RESP_OKAY;
    end else begin
      unique case (rState_r)
        PPA_R_IDLE: begin
          if (s_axi_arvalid && arReady_r) begin
            // Capture the word in the same edge that takes the address
            rState_r <= PPA_R_DATA;
            arReady_r <= 1'b0;
            rValid_r <= 1'b1;
            rData_r <= rdWord;
            rResp_r <= isMapped(s_axi_araddr) ? `PPA_RESP_OKAY : `PPA_RESP_SLVERR;
          end else begin
            arReady_r <= 1'b1;
          end
        end
        PPA_R_DATA: begin
          if (s_axi_rready) begin
            rState_r <= PPA_R_IDLE;
            rValid_r <= 1'b0;
            arReady_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // Bus outputs come straight from their flip-flops
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Pin outputs are the pad mux flip-flops
  assign portAddressPads = padState;
  assign chipSelectTwoOut = csTwo;
  assign chipSelectOneOut = csOne;

endmodule // ppa_port_top
`default_nettype wire

// [dv/ppa_port_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module ppa_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads and selects
  input wire ppa_pkg::ppa_pad_t portIo,
  input wire ppa_pkg::ppa_pad_t portAddressPads,
  input wire logic chipSelectTwoOut,
  input wire logic chipSelectOneOut
);
  import ppa_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Set once a write was answered; until then only reset values may show
  logic wrSeen_r;
  always_ff @(posedge clk) begin
    if (!rst_b) wrSeen_r <= 1'b0;
    else if (s_axi_bvalid) wrSeen_r <= 1'b1;
  end
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  AST_AR_TAKE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && !s_axi_awready ##1 s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  // Selects may only move just after a register write was answered
  // A reset in mid-run may also drop them, seen one edge after it
  AST_CS2_CAUSE: assert property ($changed(chipSelectTwoOut) |-> $past(s_axi_bvalid) || !$past(rst_b))
    else $error("second select moved without write");
  AST_CS1_CAUSE: assert property ($changed(chipSelectOneOut) |-> $past(s_axi_bvalid) || !$past(rst_b))
    else $error("first select moved without write");
  // A pad not driven by the port must copy the port I/O level
  AST_PORT_COPY: assert property ($past(rst_b) |->
    ((portAddressPads.dat ^ $past(portIo.dat)) & ~portAddressPads.oe) == 16'h0000)
    else $error("idle pad does not copy port io");
  AST_RESET_IDLE: assert property ($past(rst_b) && !wrSeen_r |-> !chipSelectTwoOut &&
    !chipSelectOneOut && portAddressPads == $past(portIo))
    else $error("pads not idle after reset");
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
  COV_CS: cover property ($rose(chipSelectTwoOut));
endmodule // ppa_port_checker
bind ppa_port_top ppa_port_checker ppa_port_checker_inst (.clk, .rst_b, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .portIo, .portAddressPads, .chipSelectTwoOut, .chipSelectOneOut);
`default_nettype wire

// [dv/ppa_ext_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module ppa_ext_dev (
  // Clock
  input wire logic clk,
  // Pads and select from the port
  input wire ppa_pkg::ppa_pad_t pads,
  input wire logic csOne,
  // Last address seen while selected
  output logic [13:0] seenAddr
);
  import ppa_pkg::*;
  // Latches the address lines while selected, as a plain memory would
  always_ff @(posedge clk) begin
    if (csOne) seenAddr <= pads.dat[13:0];
  end
endmodule // ppa_ext_dev
`default_nettype wire

// [dv/ppa_port_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ppa_port_top_tb;
  import ppa_pkg::*;
  // Bus side, all idle at time zero
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Pad side
  ppa_pad_t portIo = '{oe: 16'h0f0f, dat: 16'h5a5a};
  ppa_pad_t portAddressPads, e;
  logic latchHighStrobeIn = 1'b0, latchLowStrobeIn = 1'b0, chipSelectTwoOut, chipSelectOneOut;
  logic [13:0] seenAddr;
  logic [31:0] rd;
  logic [1:0] resp;
  int fail_count = 0, n_compared = 0, cyc = 0;
  // Cases: address, pad enable, mode, {latch high, latch low}
  logic [15:0] av[4] = '{16'hc123, 16'h4005, 16'h8002, 16'h7ffc};
  logic [15:0] pv[4] = '{16'hffff, 16'h3ffc, 16'hc003, 16'h0000};
  logic [1:0] mv[4] = '{2'h2, 2'h1, 2'h1, 2'h3};
  logic [1:0] sv[4] = '{2'b10, 2'b00, 2'b01, 2'b11};
  always #25 clk = ~clk;
  ppa_port_top ppa_port_top_inst (.*);
  ppa_ext_dev ppa_ext_dev_inst (.clk(clk), .pads(portAddressPads), .csOne(chipSelectOneOut), .seenAddr(seenAddr));
  task close_out;
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  // Expected pads; select mode shows the same bits as address mode when active high
  function automatic ppa_pad_t expPad(input logic [15:0] a, input logic [15:0] pe, input logic [1:0] m,
    input logic [1:0] s);
    ppa_pad_t x;
    if (m[1]) a[1:0] = s;
    x.oe = pe | portIo.oe;
    x.dat = (a & pe) | (portIo.dat & ~pe);
    return x;
  endfunction
  // Write: both channels offered together, each dropped when taken
  task automatic axiWr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (s_axi_awready && !awDone) begin
        s_axi_awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (s_axi_wready && !wDone) begin
        s_axi_wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One spare edge so the next call never re-raises a strobe in this step
    @(posedge clk);
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axiRd(`PPA_OFS_ADDR, rd, resp);
    `CMP(rd, 32'h00000000)
    axiRd(`PPA_OFS_PADEN, rd, resp);
    `CMP(rd, 32'h00000000)
    `CMP(portAddressPads, portIo)
    `CMP({chipSelectTwoOut, chipSelectOneOut}, 2'b00)
    for (int i = 0; i < 4; i++) begin
      {latchHighStrobeIn, latchLowStrobeIn} <= sv[i];
      axiWr(`PPA_OFS_ADDR, av[i], resp);
      `CMP(resp, `PPA_RESP_OKAY)
      axiWr(`PPA_OFS_PADEN, pv[i], resp);
      axiWr(`PPA_OFS_MODE, {14'h0000, mv[i]}, resp);
      axiRd(`PPA_OFS_ADDR, rd, resp);
      `CMP(rd, {16'h0000, av[i]})
      axiRd(`PPA_OFS_PADEN, rd, resp);
      `CMP(rd, {16'h0000, pv[i]})
      `CMP(chipSelectTwoOut, av[i][15])
      `CMP(chipSelectOneOut, av[i][14])
      e = expPad(av[i], pv[i], mv[i], sv[i]);
      `CMP({portAddressPads.oe[15:14], portAddressPads.dat[15:14]}, {e.oe[15:14], e.dat[15:14]})
      `CMP({portAddressPads.oe[13:2], portAddressPads.dat[13:2]}, {e.oe[13:2], e.dat[13:2]})
      `CMP({portAddressPads.oe[1:0], portAddressPads.dat[1:0]}, {e.oe[1:0], e.dat[1:0]})
      if (av[i][14]) `CMP(seenAddr[13:2], e.dat[13:2])
    end
    // Unmapped place is refused and leaves the registers alone
    axiWr(8'h10, 16'hffff, resp);
    `CMP(resp, `PPA_RESP_SLVERR)
    axiRd(8'h10, rd, resp);
    `CMP({resp, rd}, {`PPA_RESP_SLVERR, 32'h00000000})
    axiRd(`PPA_OFS_ADDR, rd, resp);
    `CMP(rd, {16'h0000, av[3]})
    // Read with rready held back, so the data must stand while not taken
    s_axi_araddr <= `PPA_OFS_ADDR;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    `CMP({s_axi_rvalid, s_axi_rdata}, {1'b1, 16'h0000, av[3]})
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
    // Second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axiRd(`PPA_OFS_ADDR, rd, resp);
    `CMP(rd, 32'h00000000)
    `CMP(portAddressPads, portIo)
    close_out();
  end
endmodule // ppa_port_top_tb
`default_nettype wire
